// File: include/led_cfg.svh
// Offsets, field positions, reset values and timing counts for the LED mode block
// What this block does
// - Bits 6:5 of mode one select increment range
// - Mode one bit 4 sleeps, stopping the oscillator
// - Oscillator running within 500 us after wake
// - No blink, dim or gradation while oscillator stopped
// - Sleeping during group control leaves state unknown
// - Mode one bits 3:1 enable subaddresses, first set
// - Mode one bit 0 enables broadcast address, set
// - Mode two bits 7,6 show thermal and fault
// - Mode two bit 5 picks blinking over dimming
// - Mode two bit 4 clears fault flags, self-clears
// - Mode two bit 3 applies writes on acknowledge
// - Mode two bit 2 picks exponential ramp scale
// - Four state registers, 2-bit fields, reset 10
// - State 01 fully on, only enable pin gates
// - State 10 follows individual duty only
// - State 11 combines individual and group duty
// - Individual duty at 31.25 kHz, value/256, FF fully on
// - Group dimming fixed 122 Hz, period ignored
`ifndef LED_CFG_SVH
`define LED_CFG_SVH

// Register offsets
`define OFS_MODE_ONE      7'h00
`define OFS_MODE_TWO      7'h01
`define OFS_STATE_FIRST   7'h02
`define OFS_STATE_LAST    7'h05

// Mode one fields
`define M1_AUTOINC_FLAG   7
`define M1_RANGE_HI       6
`define M1_RANGE_LO       5
`define M1_SLEEP          4
`define M1_SUB_ONE        3
`define M1_SUB_TWO        2
`define M1_SUB_THREE      1
`define M1_BROADCAST      0

// Mode two fields
`define M2_THERMAL        7
`define M2_FAULT          6
`define M2_BLINK          5
`define M2_ERR_CLEAR      4
`define M2_ON_ACK         3
`define M2_EXP_RAMP       2
`define M2_RSVD_ONE       0

// Reset values
`define MODE_ONE_RST      8'h89
`define MODE_TWO_RST      8'h01
`define STATE_FIELD_RST   2'b10
`define GROUP_DUTY_FULL   8'hFF

// Timing
`define CLK_HZ            200000000
`define PWM_FREQ_HZ       31250
`define PWM_STEPS         256
`define PWM_TICK_CYC      (`CLK_HZ / (`PWM_FREQ_HZ * `PWM_STEPS))
`define WAKE_TIME_US      500
`define WAKE_CYC          (`WAKE_TIME_US * (`CLK_HZ / 1000000))
`define BLINK_PRESCALE    8

`endif

// File: include/led_pkg.sv
// Shared types for the LED mode block
package led_pkg;
   typedef logic [1:0]  field_t;
   typedef logic [7:0]  byte_t;
   typedef logic [6:0]  addr_t;
   typedef enum logic [1:0] {
      CH_OFF,
      CH_FULL_ON,
      CH_INDIV,
      CH_INDIV_GROUP
   } chan_mode_e;
   typedef enum {
      OSC_RUN,
      OSC_STOPPED,
      OSC_WAKING
   } osc_state_e;
endpackage

// File: include/led_timing_if.sv
// Oscillator and PWM timebase signals shared inside the block
`timescale 1ns/1ps
interface led_timing_if;
   logic       sleep_req;
   logic       osc_on;
   logic       osc_ready;
   logic [7:0] pwm_cnt;
   logic [7:0] grp_cnt;
   logic [7:0] blink_cnt;
   logic [7:0] blink_period;

   modport ctl (output sleep_req, output blink_period,
                input osc_on, input osc_ready, input pwm_cnt, input grp_cnt, input blink_cnt);
   modport osc (input sleep_req, output osc_on, output osc_ready);
   modport tb  (input osc_on, input blink_period,
                output pwm_cnt, output grp_cnt, output blink_cnt);
endinterface

// File: logic/osc_wake.sv
// Oscillator sleep and wake timer
`timescale 1ns/1ps
`include "led_cfg.svh"
module osc_wake #(
   parameter int WAKE_CYCLES = `WAKE_CYC
) (
   input  wire logic sys_clk_in,
   input  wire logic srst_in,
   led_timing_if.osc tmg
);
   import led_pkg::*;

   osc_state_e  state;
   logic [31:0] wake_cnt;

   ////////////////////////////////////////////////////////////////////////////
   // Sleep stops the oscillator; wake waits the full settle window
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         state    <= OSC_RUN;
         wake_cnt <= '0;
      end else begin
         case (state)
            OSC_RUN: begin
               if (tmg.sleep_req) state <= OSC_STOPPED;
            end
            OSC_STOPPED: begin
               wake_cnt <= '0;
               if (!tmg.sleep_req) state <= OSC_WAKING;
            end
            OSC_WAKING: begin
               if (tmg.sleep_req) begin
                  state <= OSC_STOPPED;
               end else if (wake_cnt == 32'(WAKE_CYCLES - 1)) begin
                  state <= OSC_RUN;
               end else begin
                  wake_cnt <= wake_cnt + 32'd1;
               end
            end
            default: state <= OSC_RUN;
         endcase
      end
   end

   // Ready only once settled, so group outputs never run on a half-started clock
   assign tmg.osc_on    = (state != OSC_STOPPED);
   assign tmg.osc_ready = (state == OSC_RUN);
endmodule

// File: logic/pwm_timebase.sv
// Shared PWM, group dimming and group blinking counters
`timescale 1ns/1ps
`include "led_cfg.svh"
module pwm_timebase #(
   parameter int TICK_CYCLES = `PWM_TICK_CYC
) (
   input  wire logic sys_clk_in,
   input  wire logic srst_in,
   led_timing_if.tb  tmg
);
   import led_pkg::*;

   logic [7:0]  div_cnt;
   logic        step;
   logic [2:0]  pre_cnt;
   logic [7:0]  per_cnt;
   logic        pwm_wrap;
   logic        blink_step;

   assign step       = tmg.osc_on && (div_cnt == 8'(TICK_CYCLES - 1));
   assign pwm_wrap   = step && (tmg.pwm_cnt == 8'hFF);
   assign blink_step = pwm_wrap && (pre_cnt == 3'(`BLINK_PRESCALE - 1))
                       && (per_cnt == tmg.blink_period);

   ////////////////////////////////////////////////////////////////////////////
   // Step divider: 256 steps per individual period
   always_ff @(posedge sys_clk_in) begin
      if (srst_in || !tmg.osc_on) div_cnt <= '0;
      else if (step)              div_cnt <= '0;
      else                        div_cnt <= div_cnt + 8'd1;
   end

   // Individual counter, 31.25 kHz wrap
   always_ff @(posedge sys_clk_in) begin
      if (srst_in)   tmg.pwm_cnt <= '0;
      else if (step) tmg.pwm_cnt <= tmg.pwm_cnt + 8'd1;
   end

   // Group dimming counter steps once per individual period: 122 Hz
   always_ff @(posedge sys_clk_in) begin
      if (srst_in)       tmg.grp_cnt <= '0;
      else if (pwm_wrap) tmg.grp_cnt <= tmg.grp_cnt + 8'd1;
   end

   // Blink step every prescale x (period+1) individual periods
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         pre_cnt       <= '0;
         per_cnt       <= '0;
         tmg.blink_cnt <= '0;
      end else if (pwm_wrap) begin
         pre_cnt <= pre_cnt + 3'd1;
         if (pre_cnt == 3'(`BLINK_PRESCALE - 1)) begin
            per_cnt <= (per_cnt == tmg.blink_period) ? 8'd0 : per_cnt + 8'd1;
         end
         if (blink_step) tmg.blink_cnt <= tmg.blink_cnt + 8'd1;
      end
   end
endmodule

// File: logic/led_mode_regs.sv
// Mode and output-state registers with per-channel output selection
`timescale 1ns/1ps
`include "led_cfg.svh"
module led_mode_regs #(
   parameter int CHANNELS    = 16,
   parameter int WAKE_CYCLES = `WAKE_CYC
) (
   input  wire logic                    sys_clk_in,
   input  wire logic                    srst_in,
   input  wire logic                    reg_wr_in,
   input  wire led_pkg::addr_t          reg_addr_in,
   input  wire led_pkg::byte_t          reg_wdata_in,
   output led_pkg::byte_t               reg_rd_data_out,
   input  wire logic                    ack_in,
   input  wire logic                    stop_in,
   input  wire logic                    autoinc_active_in,
   input  wire logic                    thermal_alarm_in,
   input  wire logic [CHANNELS-1:0]     fault_detect_in,
   input  wire logic [CHANNELS*8-1:0]   channel_duty_in,
   input  wire led_pkg::byte_t          group_duty_in,
   input  wire led_pkg::byte_t          group_period_in,
   input  wire logic                    out_enable_n_in,
   output logic [CHANNELS-1:0]          led_drive_out,
   output logic [CHANNELS-1:0]          fault_flag_regs_out,
   output logic                         autoinc_range_hi_out,
   output logic                         autoinc_range_lo_out,
   output logic                         subaddr_one_enable_out,
   output logic                         subaddr_two_enable_out,
   output logic                         subaddr_three_enable_out,
   output logic                         broadcast_addr_enable_out,
   output logic                         exponential_ramp_select_out,
   output logic                         gradation_run_out,
   output logic                         osc_ready_out,
   output logic                         reset_advised_out
);
   import led_pkg::*;

   localparam int STATE_REGS = CHANNELS / 4;
   localparam int IDX_W      = $clog2(STATE_REGS);

   led_timing_if tmg ();

   byte_t               mode_one;
   byte_t               mode_two;
   logic [7:0]          state_wr [STATE_REGS];
   logic [7:0]          state_act [STATE_REGS];
   logic                commit_pend;
   logic                commit;
   logic                wr_mode_one;
   logic                wr_mode_two;
   logic [CHANNELS-1:0] next_drive;
   logic                any_group;
   logic                any_group_wr;

   // Field of channel n in a register bank
   function automatic field_t field_of(input logic [7:0] regs [STATE_REGS], input int n);
      field_of = regs[n / 4][(n % 4) * 2 +: 2];
   endfunction

   // Duty compare, full scale meaning always on only when full is set
   function automatic logic duty_on(input byte_t duty, input byte_t cnt, input logic full);
      duty_on = (full && duty == 8'hFF) || (cnt < duty);
   endfunction

   // Bank index from a bus offset; cut to the bank width on purpose
   function automatic logic [IDX_W-1:0] state_idx(input addr_t a);
      state_idx = IDX_W'(a - `OFS_STATE_FIRST);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Submodules
   osc_wake #(
      .WAKE_CYCLES (WAKE_CYCLES)
   ) u_osc (
      .sys_clk_in (sys_clk_in),
      .srst_in    (srst_in),
      .tmg        (tmg)
   );

   pwm_timebase u_tb (
      .sys_clk_in (sys_clk_in),
      .srst_in    (srst_in),
      .tmg        (tmg)
   );

   assign tmg.sleep_req    = mode_one[`M1_SLEEP];
   assign tmg.blink_period = group_period_in;

   ////////////////////////////////////////////////////////////////////////////
   // Write decode
   assign wr_mode_one = reg_wr_in && (reg_addr_in == `OFS_MODE_ONE);
   assign wr_mode_two = reg_wr_in && (reg_addr_in == `OFS_MODE_TWO);

   // Mode one: flag bit follows the increment state, never written
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         mode_one <= `MODE_ONE_RST;
      end else begin
         mode_one[`M1_AUTOINC_FLAG] <= autoinc_active_in;
         if (wr_mode_one) begin
            mode_one[6:0] <= reg_wdata_in[6:0];
         end
      end
   end

   // Mode two: only blink, ack-update and ramp-scale bits take writes
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         mode_two <= `MODE_TWO_RST;
      end else if (wr_mode_two) begin
         mode_two[`M2_BLINK]    <= reg_wdata_in[`M2_BLINK];
         mode_two[`M2_ON_ACK]   <= reg_wdata_in[`M2_ON_ACK];
         mode_two[`M2_EXP_RAMP] <= reg_wdata_in[`M2_EXP_RAMP];
      end
   end

   // Fault flags: a new detection in the clear cycle still sets
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         fault_flag_regs_out <= '0;
      end else if (wr_mode_two && reg_wdata_in[`M2_ERR_CLEAR]) begin
         fault_flag_regs_out <= fault_detect_in;
      end else begin
         fault_flag_regs_out <= fault_flag_regs_out | fault_detect_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output-state registers: written copy reads back, active copy drives
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         for (int i = 0; i < STATE_REGS; i++) begin
            state_wr[i] <= {4{`STATE_FIELD_RST}};
         end
      end else if (reg_wr_in && reg_addr_in >= `OFS_STATE_FIRST
                   && reg_addr_in <= `OFS_STATE_LAST) begin
         state_wr[state_idx(reg_addr_in)] <= reg_wdata_in;
      end
   end

   // Pending update waits for ack or stop, as selected
   assign commit = commit_pend
                   && (mode_two[`M2_ON_ACK] ? ack_in : stop_in);

   always_ff @(posedge sys_clk_in) begin
      if (srst_in)        commit_pend <= 1'b0;
      else if (reg_wr_in) commit_pend <= 1'b1;
      else if (commit)    commit_pend <= 1'b0;
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         for (int i = 0; i < STATE_REGS; i++) begin
            state_act[i] <= {4{`STATE_FIELD_RST}};
         end
      end else if (commit) begin
         state_act <= state_wr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read mux; unmapped offsets read zero
   always_comb begin
      reg_rd_data_out = 8'h00;
      if (reg_addr_in == `OFS_MODE_ONE) begin
         reg_rd_data_out = mode_one;
      end else if (reg_addr_in == `OFS_MODE_TWO) begin
         reg_rd_data_out = mode_two;
         reg_rd_data_out[`M2_THERMAL] = thermal_alarm_in;
         reg_rd_data_out[`M2_FAULT]   = |fault_flag_regs_out;
      end else if (reg_addr_in >= `OFS_STATE_FIRST && reg_addr_in <= `OFS_STATE_LAST) begin
         reg_rd_data_out = state_wr[state_idx(reg_addr_in)];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel output selection; pin enable gates every output
   always_comb begin
      logic  grp_on;
      byte_t duty;
      duty   = 8'h00;
      grp_on = mode_two[`M2_BLINK] ? duty_on(group_duty_in, tmg.blink_cnt, 1'b0)
                                   : duty_on(group_duty_in, tmg.grp_cnt, 1'b0);
      for (int n = 0; n < CHANNELS; n++) begin
         duty = channel_duty_in[n*8 +: 8];
         case (chan_mode_e'(field_of(state_act, n)))
            CH_OFF:         next_drive[n] = 1'b0;
            CH_FULL_ON:     next_drive[n] = !out_enable_n_in;
            CH_INDIV:       next_drive[n] = !out_enable_n_in && tmg.osc_ready
                                            && duty_on(duty, tmg.pwm_cnt, 1'b1);
            CH_INDIV_GROUP: next_drive[n] = !out_enable_n_in && tmg.osc_ready && grp_on
                                            && duty_on(duty, tmg.pwm_cnt, 1'b1);
            default:        next_drive[n] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) led_drive_out <= '0;
      else         led_drive_out <= next_drive;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sleep while on group control, or 11 programmed before wake completes: advise reset
   always_comb begin
      any_group    = 1'b0;
      any_group_wr = 1'b0;
      for (int n = 0; n < CHANNELS; n++) begin
         any_group    = any_group    | (field_of(state_act, n) == 2'b11);
         any_group_wr = any_group_wr | (field_of(state_wr, n) == 2'b11);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         reset_advised_out <= 1'b0;
      end else if ((mode_one[`M1_SLEEP] && any_group)
                   || (!tmg.osc_ready && !mode_one[`M1_SLEEP] && any_group_wr)) begin
         reset_advised_out <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control fields out to the bus front end and gradation engine
   assign autoinc_range_hi_out        = mode_one[`M1_RANGE_HI];
   assign autoinc_range_lo_out        = mode_one[`M1_RANGE_LO];
   assign subaddr_one_enable_out      = mode_one[`M1_SUB_ONE];
   assign subaddr_two_enable_out      = mode_one[`M1_SUB_TWO];
   assign subaddr_three_enable_out    = mode_one[`M1_SUB_THREE];
   assign broadcast_addr_enable_out   = mode_one[`M1_BROADCAST];
   assign exponential_ramp_select_out = mode_two[`M2_EXP_RAMP];
   assign gradation_run_out           = tmg.osc_ready;
   assign osc_ready_out               = tmg.osc_ready;
endmodule

// File: dv/led_mode_regs_assertions.sv
// Port-level assertions for the mode and output-state register block
`timescale 1ns/1ps
module led_mode_chk #(
   parameter int WAKE_CYCLES = 50
) (
   input wire logic           sys_clk_in,
   input wire logic           srst_in,
   input wire logic           reg_wr_in,
   input wire led_pkg::addr_t reg_addr_in,
   input wire led_pkg::byte_t reg_wdata_in,
   input wire led_pkg::byte_t reg_rd_data_out,
   input wire logic           autoinc_active_in,
   input wire logic           thermal_alarm_in,
   input wire logic [15:0]    fault_detect_in,
   input wire logic [15:0]    fault_flag_regs_out,
   input wire logic           out_enable_n_in,
   input wire logic [15:0]    led_drive_out,
   input wire logic           osc_ready_out
);
   import led_pkg::*;
   // Wake bound allows a few cycles of decode slack
   localparam int WMAX = WAKE_CYCLES + 4;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);
   ////////////////////////////////////////////////////////////////////////////////
   a_thermal_live: assert property (reg_addr_in == 7'h01 |->
      reg_rd_data_out[7] == thermal_alarm_in) else $error("thermal bit wrong");
   a_fault_summary: assert property (reg_addr_in == 7'h01 |->
      reg_rd_data_out[6] == |fault_flag_regs_out) else $error("fault summary wrong");
   a_fixed_bits_read: assert property (reg_addr_in == 7'h01 |->
      reg_rd_data_out[4] == 1'b0 && reg_rd_data_out[1:0] == 2'b01) else $error("fixed bits");
   a_autoinc_flag: assert property (reg_addr_in == 7'h00 && $stable(autoinc_active_in)
      |-> reg_rd_data_out[7] == autoinc_active_in) else $error("increment flag wrong");
   a_flags_sticky: assert property (!(reg_wr_in && reg_addr_in == 7'h01 && reg_wdata_in[4])
      |=> fault_flag_regs_out == ($past(fault_flag_regs_out) | $past(fault_detect_in)))
      else $error("flags not sticky");
   a_clear_flags: assert property (reg_wr_in && reg_addr_in == 7'h01 && reg_wdata_in[4]
      |=> fault_flag_regs_out == $past(fault_detect_in)) else $error("clear failed");
   a_enable_gates: assert property (out_enable_n_in ##1 out_enable_n_in
      |-> led_drive_out == 16'h0000) else $error("drive while disabled");
   a_sleep_stops: assert property (reg_wr_in && reg_addr_in == 7'h00 && reg_wdata_in[4]
      |-> ##[1:2] !osc_ready_out) else $error("oscillator kept running");
   a_wake_bound: assert property (reg_wr_in && reg_addr_in == 7'h00 && !reg_wdata_in[4]
      && !osc_ready_out |-> ##[1:WMAX] osc_ready_out) else $error("wake too slow");
endmodule
bind led_mode_regs led_mode_chk #(.WAKE_CYCLES(WAKE_CYCLES)) chk (.*);

// File: dv/led_host_model.sv
// Host controller model driving the register strobe port
`timescale 1ns/1ps
module led_host_model (
   input  wire logic           sys_clk_in,
   input  wire logic           osc_ready_in,
   input  wire logic           reset_advised_in,
   input  wire led_pkg::byte_t rd_data_in,
   output logic                srst_out,
   output logic                wr_out,
   output led_pkg::addr_t      addr_out,
   output led_pkg::byte_t      wdata_out,
   output logic                ack_out,
   output logic                stop_out,
   output logic [127:0]        duty_out,
   output led_pkg::byte_t      gduty_out,
   output led_pkg::byte_t      gper_out,
   output logic                oe_n_out
);
   import led_pkg::*;
   // Idle values at time zero, reset asserted
   initial begin
      srst_out = 1'b1;
      wr_out = 1'b0;
      addr_out = 7'h7F;
      wdata_out = 8'h00;
      ack_out = 1'b0;
      stop_out = 1'b0;
      duty_out = '0;
      gduty_out = 8'h00;
      gper_out = 8'h00;
      oe_n_out = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic reset();
      @(posedge sys_clk_in) srst_out <= 1'b1;
      repeat (12) @(posedge sys_clk_in);
      srst_out <= 1'b0;
   endtask
   // One strobe per byte, never two in adjacent cycles
   task automatic wr(input addr_t a, input byte_t d);
      @(posedge sys_clk_in);
      wr_out <= 1'b1;
      addr_out <= a;
      wdata_out <= d;
      @(posedge sys_clk_in) wr_out <= 1'b0;
   endtask
   task automatic rd(input addr_t a, output byte_t d);
      @(posedge sys_clk_in) addr_out <= a;
      @(negedge sys_clk_in) d = rd_data_in;
   endtask
   // Bus event pulse: 1 is acknowledge, 0 is stop
   task automatic pulse(input bit on_ack);
      @(posedge sys_clk_in);
      if (on_ack) ack_out <= 1'b1;
      else stop_out <= 1'b1;
      @(posedge sys_clk_in);
      ack_out <= 1'b0;
      stop_out <= 1'b0;
   endtask
   // Duty values are held off until the oscillator has settled
   task automatic set_duty(input logic [127:0] d);
      while (osc_ready_in !== 1'b1) @(posedge sys_clk_in);
      @(posedge sys_clk_in) duty_out <= d;
   endtask
   // Group duty and blink period, changed on a rising edge
   task automatic set_group(input byte_t g, input byte_t p);
      @(posedge sys_clk_in);
      gduty_out <= g;
      gper_out <= p;
   endtask
   // External output enable pin, active low
   task automatic set_oe(input bit v);
      @(posedge sys_clk_in) oe_n_out <= v;
   endtask
   // Full reset when the device flags an unknown output state
   task automatic recover();
      if (reset_advised_in === 1'b1) reset();
   endtask
endmodule

// File: dv/led_mode_regs_test.sv
// Self-checking bench for the mode and output-state register block
`timescale 1ns/1ps
module led_mode_regs_test;
   import led_pkg::*;
   localparam int WAKE = 50;
   logic        sys_clk_in, autoinc, thermal, ready, advised, expo, grad;
   logic        srst, wr, ack, stop, oe_n, r_hi, r_lo, s1, s2, s3, bc;
   logic [15:0] fault, drive, flags;
   logic [127:0] duty;
   addr_t       addr;
   byte_t       wdata, rdata, gduty, gper, rv;
   int          n_fail, n_tests, cyc, cnt;
   led_mode_regs #(.WAKE_CYCLES(WAKE)) uut (.sys_clk_in(sys_clk_in), .srst_in(srst),
      .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rd_data_out(rdata),
      .ack_in(ack), .stop_in(stop), .autoinc_active_in(autoinc), .thermal_alarm_in(thermal),
      .fault_detect_in(fault), .channel_duty_in(duty), .group_duty_in(gduty),
      .group_period_in(gper), .out_enable_n_in(oe_n), .led_drive_out(drive),
      .fault_flag_regs_out(flags), .autoinc_range_hi_out(r_hi), .autoinc_range_lo_out(r_lo),
      .subaddr_one_enable_out(s1), .subaddr_two_enable_out(s2),
      .subaddr_three_enable_out(s3), .broadcast_addr_enable_out(bc),
      .exponential_ramp_select_out(expo), .gradation_run_out(grad), .osc_ready_out(ready),
      .reset_advised_out(advised));
   led_host_model host (.sys_clk_in(sys_clk_in), .osc_ready_in(ready),
      .reset_advised_in(advised), .rd_data_in(rdata), .srst_out(srst), .wr_out(wr),
      .addr_out(addr), .wdata_out(wdata), .ack_out(ack), .stop_out(stop),
      .duty_out(duty), .gduty_out(gduty), .gper_out(gper), .oe_n_out(oe_n));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk_in = 1'b0;
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end
   // Hang guard, well above the longest expected run
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rdc(input addr_t a, input byte_t e);
      host.rd(a, rv);
      chk(16'(rv), 16'(e));
   endtask
   // Let a commit reach the registered drive outputs
   task automatic settle();
      repeat (2) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
   endtask
   task automatic tally_and_finish();
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      n_fail = 0;
      n_tests = 0;
      autoinc = 1'b1;
      thermal = 1'b0;
      fault = 16'h0000;
      host.reset();
      rdc(7'h00, 8'h89);
      rdc(7'h01, 8'h01);
      for (int a = 2; a < 6; a++) rdc(7'(a), 8'hAA);
      rdc(7'h10, 8'h00);
      chk(16'({s1, s2, s3, bc, expo}), 16'h0012);
      $display("test reset done");
      host.wr(7'h00, 8'h6E);
      rdc(7'h00, 8'hEE);
      chk(16'({r_hi, r_lo, s1, s2, s3, bc}), 16'h003E);
      @(posedge sys_clk_in) autoinc <= 1'b0;
      rdc(7'h00, 8'h6E);
      @(posedge sys_clk_in) autoinc <= 1'b1;
      host.wr(7'h00, 8'h09);
      host.wr(7'h01, 8'hFF);
      rdc(7'h01, 8'h2D);
      chk(16'(expo), 16'h0001);
      @(posedge sys_clk_in) thermal <= 1'b1;
      rdc(7'h01, 8'hAD);
      @(posedge sys_clk_in) thermal <= 1'b0;
      host.wr(7'h01, 8'h00);
      @(posedge sys_clk_in) fault <= 16'h0005;
      @(posedge sys_clk_in) fault <= 16'h0000;
      @(negedge sys_clk_in) chk(flags, 16'h0005);
      rdc(7'h01, 8'h41);
      host.wr(7'h01, 8'h10);
      rdc(7'h01, 8'h01);
      $display("test mode done");
      host.set_duty(128'h00FF_00FF);
      settle();
      chk(drive, 16'h0005);
      host.wr(7'h02, 8'hA4);
      rdc(7'h02, 8'hA4);
      chk(drive, 16'h0005);
      host.pulse(0);
      settle();
      chk(drive, 16'h0006);
      host.set_oe(1'b1);
      settle();
      chk(drive, 16'h0000);
      host.set_oe(1'b0);
      host.wr(7'h01, 8'h08);
      host.wr(7'h02, 8'h55);
      host.pulse(0);
      settle();
      chk(drive, 16'h0006);
      host.pulse(1);
      settle();
      chk(drive, 16'h000F);
      host.wr(7'h01, 8'h00);
      host.wr(7'h02, 8'hFF);
      host.pulse(0);
      settle();
      chk(drive, 16'h0000);
      host.set_group(8'hFF, 8'h03);
      settle();
      chk(drive, 16'h0005);
      $display("test states done");
      host.wr(7'h02, 8'h02);
      host.set_duty(128'h80);
      host.pulse(0);
      settle();
      cnt = 0;
      repeat (6400) @(negedge sys_clk_in) cnt += int'(drive[0]);
      chk(16'(cnt > 3170 && cnt < 3230), 16'h0001);
      host.set_duty(128'hFF);
      host.wr(7'h00, 8'h19);
      settle();
      chk(16'({ready, grad, drive[0]}), 16'h0000);
      host.wr(7'h00, 8'h09);
      cnt = 0;
      while (ready !== 1'b1 && cnt < 200) begin
         @(negedge sys_clk_in);
         cnt++;
      end
      chk(16'(cnt >= WAKE - 4 && cnt <= WAKE + 4), 16'h0001);
      settle();
      chk(16'({grad, drive[0]}), 16'h0003);
      host.wr(7'h00, 8'h19);
      host.wr(7'h00, 8'h09);
      host.wr(7'h02, 8'h03);
      settle();
      chk(16'(advised), 16'h0001);
      host.recover();
      rdc(7'h02, 8'hAA);
      chk(16'(advised), 16'h0000);
      $display("test power done");
      tally_and_finish();
   end
endmodule
